// File: verilog/sac_axis.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01: axis kind is rotary, translation or aperture; rotary shows degrees.
// RULE_02: rotary display is position modulo one turn; full count kept.
// RULE_03: moves use the accumulated count, so reverse travel may exceed a turn.
// RULE_04: step counter magnitude never exceeds two to the 23rd minus one.
// RULE_05: steps per unit equal scale multiplier over scale divider.
// RULE_06: targets are truncated to whole motor steps.
// RULE_07: reference offset loads position at power-on, reset and home found.
// RULE_08: home, run and fast rates held per axis; 1500, 250, 2500.
// RULE_09: home search steps at the home search rate.
// RULE_10: fast jog starts at run rate, ramps to fast, ramps back down.
// RULE_11: operator keeps run rate below motor start-stop frequency.
// RULE_12: direction level bit inverts the direction output.
// RULE_13: limit assignment bit picks which limit input guards which way.
// RULE_14: input port watched only while the watch setting is one.
// RULE_15: watched rising input edge stops all motion at once.
// RULE_16: save confirmation writes the whole parameter set to storage.
// RULE_17: unsaved edits live only in volatile copies, lost on reset.
// RULE_18: serial or parallel host selectable; parallel has an address only.
// RULE_19: serial baud 2400 to 19200, 7/8 data, 1/2 stop, four parities.
// RULE_20: replies end with line feed or carriage return as configured.
// RULE_21: host ends each command with carriage return then line feed.
// RULE_22: limit event stops motion and is reported in status.
// RULE_23: counter is 24-bit two's complement; out-of-range targets refused.
// RULE_24: stop suppresses step pulses from the cycle after the event.
module sac_axis #(
  parameter int IN_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // settings editing and storage
  input wire logic cfg_wr,
  input wire sac_pkg::sac_cfg_t cfg_in,
  input wire sac_pkg::sac_glob_t glob_in,
  input wire logic save_yes,
  input wire sac_pkg::sac_nv_t nv_rdata,
  output sac_pkg::sac_nv_t nv_wdata,
  output logic nv_wr,
  // motion commands
  input wire logic move_req,
  input wire logic signed [15:0] move_target,
  input wire logic home_req,
  input wire logic home_neg,
  input wire logic home_found,
  input wire logic jog_run,
  input wire logic jog_fast,
  input wire logic jog_neg,
  input wire logic stop_req,
  output logic move_refused,
  output logic busy,
  // field signals
  input wire logic lim_a,
  input wire logic lim_b,
  input wire logic [IN_W-1:0] watch_in,
  output logic step_out,
  output logic dir_out,
  // position and status
  output logic signed [23:0] pos,
  output logic signed [26:0] disp_pos,
  output logic disp_deg,
  input wire logic stat_clr,
  output sac_pkg::sac_stat_t status,
  // host link
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic cmd_end,
  output sac_pkg::sac_link_t link
);
  import sac_pkg::*;

  typedef enum logic [2:0] {
    m_idle, m_move, m_home, m_run, m_fast, m_decel
  } sac_mode_t;

  sac_cfg_t cfg;
  sac_glob_t glob;
  sac_mode_t mode;
  logic load_pend;
  logic move_neg;
  logic signed [23:0] target;
  logic [15:0] cur_rate;
  logic [$clog2(RAMP_CYC)-1:0] ramp_cnt;
  logic [24:0] acc;
  logic [IN_W-1:0] watch_prev;
  logic saw_cr;

  // ***********************
  // combinational helpers
  // ***********************
  logic [15:0] dv;
  logic signed [33:0] prod;
  logic signed [33:0] quo;
  logic in_range;
  logic [25:0] turn;
  logic signed [26:0] rem;
  logic lim_pos;
  logic lim_neg;
  logic blocked;
  logic at_end;
  logic watch_rise;
  logic estop_evt;
  logic [15:0] rate;
  logic [25:0] acc_sum;
  logic fire;
  logic ramp_tick;

  // zero divider treated as one to keep the divide defined
  assign dv = (cfg.steps_scale_div == 16'h0000) ? 16'h0001
              : cfg.steps_scale_div;
  // units to steps, truncation drops any sub-step part
  assign prod = $signed({{18{move_target[15]}}, move_target})
              * $signed({18'h00000, cfg.steps_scale_mult}); // RULE_05
  assign quo = prod / $signed({18'h00000, dv}); // RULE_06
  assign in_range = (quo <= $signed(34'(STEP_MAX)))
                 && (quo >= -$signed(34'(STEP_MAX))); // RULE_23
  assign turn = 26'(({10'h000, cfg.steps_scale_mult} * 26'(DEG_TURN))
              / {10'h000, dv});
  assign rem = $signed({{3{pos[23]}}, pos})
             % $signed({1'b0, (turn == 26'h0) ? 26'h1 : turn});
  // assignment bit swaps which input guards the positive side
  assign lim_pos = cfg.lim_assign ? lim_b : lim_a; // RULE_13
  assign lim_neg = cfg.lim_assign ? lim_a : lim_b; // RULE_13
  assign blocked = (mode != m_idle) && (move_neg ? lim_neg : lim_pos);
  assign at_end = move_neg ? (pos == POS_MIN) : (pos == POS_MAX); // RULE_04
  assign watch_rise = glob.io_watch
                    && |(watch_in & ~watch_prev); // RULE_14 RULE_15
  assign estop_evt = stop_req || watch_rise || blocked; // RULE_22
  always_comb begin
    unique case (mode)
      m_home: rate = cfg.home_search_step_rate; // RULE_09
      m_fast, m_decel: rate = cur_rate;
      default: rate = cfg.run_rate; // RULE_08
    endcase
  end
  assign acc_sum = {1'b0, acc} + {10'h000, rate};
  assign fire = (mode != m_idle) && !at_end && !load_pend
             && !(mode == m_move && pos == target)
             && (acc_sum >= 26'(CLK_HZ));
  assign ramp_tick = (ramp_cnt == ($clog2(RAMP_CYC))'(RAMP_CYC - 1));

  // ***********************
  // settings, volatile and saved
  // ***********************
  // working copy reloads from storage one cycle after reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg <= CFG_DEF;
      glob <= GLOB_DEF;
      load_pend <= 1'b1;
    end else if (load_pend) begin
      cfg <= nv_rdata.cfg; // RULE_17
      glob <= nv_rdata.glob;
      load_pend <= 1'b0;
    end else if (cfg_wr) begin
      cfg <= cfg_in; // RULE_17
      glob <= glob_in;
    end
  end

  // one write pulse carries the whole image
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_wr <= 1'b0;
      nv_wdata <= '{cfg: CFG_DEF, glob: GLOB_DEF};
    end else begin
      nv_wr <= save_yes && !load_pend; // RULE_16
      nv_wdata <= '{cfg: cfg, glob: glob}; // RULE_16
    end
  end

  // ***********************
  // motion sequencer
  // ***********************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode <= m_idle;
      move_neg <= 1'b0;
      target <= 24'sh000000;
      cur_rate <= CFG_DEF.run_rate;
      move_refused <= 1'b0;
    end else begin
      move_refused <= 1'b0;
      if (estop_evt) begin
        mode <= m_idle; // RULE_15 RULE_22
      end else begin
        unique case (mode)
          m_idle: begin
            if (load_pend) begin
              mode <= m_idle;
            end else if (move_req) begin
              if (!in_range) begin
                move_refused <= 1'b1; // RULE_23
              end else if (quo[23:0] != pos) begin
                // distance from full count, not the shown value
                target <= quo[23:0]; // RULE_03
                move_neg <= $signed(quo[23:0]) < pos; // RULE_03
                mode <= m_move;
              end
            end else if (home_req) begin
              move_neg <= home_neg;
              mode <= m_home;
            end else if (jog_fast) begin
              move_neg <= jog_neg;
              cur_rate <= cfg.run_rate; // RULE_10
              mode <= m_fast;
            end else if (jog_run) begin
              move_neg <= jog_neg;
              mode <= m_run;
            end
          end
          m_move: if (pos == target || at_end) mode <= m_idle;
          m_home: if (home_found || at_end) mode <= m_idle;
          m_run: if (!jog_run || at_end) mode <= m_idle;
          m_fast: begin
            if (!jog_fast || at_end) begin
              mode <= at_end ? m_idle : m_decel; // RULE_10
            end else if (ramp_tick && cur_rate < cfg.fast_rate) begin
              cur_rate <= (cfg.fast_rate - cur_rate > RAMP_INC)
                          ? cur_rate + RAMP_INC : cfg.fast_rate; // RULE_10
            end
          end
          m_decel: begin
            if (cur_rate <= cfg.run_rate || at_end) begin
              mode <= m_idle; // RULE_10
            end else if (ramp_tick) begin
              cur_rate <= (cur_rate - cfg.run_rate > RAMP_INC)
                          ? cur_rate - RAMP_INC : cfg.run_rate;
            end
          end
        endcase
      end
    end
  end

  // ramp interval counter, free running
  always_ff @(posedge sys_clk) begin
    if (reset || ramp_tick) ramp_cnt <= '0;
    else ramp_cnt <= ramp_cnt + 1'b1;
  end

  // ***********************
  // step generation and count
  // ***********************
  // phase accumulator, rates stay far below the clock
  always_ff @(posedge sys_clk) begin
    if (reset || mode == m_idle) acc <= '0;
    else if (fire) acc <= 25'(acc_sum - 26'(CLK_HZ));
    else acc <= acc_sum[24:0];
  end

  // pulse gated by the event of the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      step_out <= 1'b0;
      dir_out <= CFG_DEF.dir_level;
    end else begin
      step_out <= fire && !estop_evt; // RULE_24
      dir_out <= move_neg ^ cfg.dir_level; // RULE_12
    end
  end

  // count loads the offset after reset and after homing
  always_ff @(posedge sys_clk) begin
    if (reset) pos <= 24'sh000000;
    else if (load_pend) pos <= nv_rdata.cfg.ref_off; // RULE_07
    else if (mode == m_home && home_found) pos <= cfg.ref_off; // RULE_07
    else if (fire && !estop_evt) pos <= move_neg ? pos - 24'sh1
                                                 : pos + 24'sh1; // RULE_04
  end

  // ***********************
  // watch, status, display
  // ***********************
  // history keeps tracking, so enabling never fires on old levels
  always_ff @(posedge sys_clk) begin
    if (reset) watch_prev <= '0;
    else watch_prev <= watch_in;
  end

  // sticky flags, a new event beats a clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status.lim_pos_hit <= (blocked && !move_neg)
                         || (status.lim_pos_hit && !stat_clr); // RULE_22
      status.lim_neg_hit <= (blocked && move_neg)
                         || (status.lim_neg_hit && !stat_clr); // RULE_22
      status.watch_hit <= watch_rise || (status.watch_hit && !stat_clr);
      status.stop_hit <= stop_req || (status.stop_hit && !stat_clr);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      disp_pos <= '0;
      disp_deg <= 1'b1;
      busy <= 1'b0;
    end else begin
      disp_deg <= (cfg.kind == rotary_axis_type); // RULE_01
      if (cfg.kind == rotary_axis_type) begin
        disp_pos <= rem[26] ? rem + $signed({1'b0, turn}) : rem; // RULE_02
      end else begin
        disp_pos <= 27'(pos); // RULE_01
      end
      busy <= (mode != m_idle);
    end
  end

  // ***********************
  // host link settings
  // ***********************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link <= '0;
      cmd_end <= 1'b0;
      saw_cr <= 1'b0;
    end else begin
      link.host_serial <= glob.host_serial; // RULE_18
      link.gpib_addr <= glob.gpib_addr; // RULE_18
      unique case (glob.baud_sel)
        2'h0: link.baud_div <= 14'(CLK_HZ / BAUD_0); // RULE_19
        2'h1: link.baud_div <= 14'(CLK_HZ / BAUD_1);
        2'h2: link.baud_div <= 14'(CLK_HZ / BAUD_2);
        2'h3: link.baud_div <= 14'(CLK_HZ / BAUD_3);
      endcase
      link.data8 <= glob.data8; // RULE_19
      link.stop2 <= glob.stop2;
      link.parity <= glob.parity;
      link.term_char <= glob.term_cr ? CHAR_CR : CHAR_LF; // RULE_20
      // command ends only on the fixed pair, whatever the reply end
      if (rx_valid) saw_cr <= (rx_byte == CHAR_CR); // RULE_21
      cmd_end <= rx_valid && saw_cr && (rx_byte == CHAR_LF); // RULE_21
    end
  end

  // ***********************
  // checks
  // ***********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_watch_edge;
    glob.io_watch && |(watch_in & ~watch_prev);
  endsequence
  sequence s_halted;
    (mode == m_idle) ##1 !step_out;
  endsequence
  sequence s_fast_start;
    mode == m_idle && !load_pend && !move_req && !home_req && jog_fast
      && !estop_evt;
  endsequence

  AST_STOP_GAP: assert property (estop_evt |=> !step_out) // RULE_24
    else $error("step pulse after stop event");
  AST_WATCH_STOP: assert property (s_watch_edge |=> s_halted) // RULE_15
    else $error("watched edge did not halt motion");
  AST_NO_WATCH: assert property (
    !glob.io_watch && !status.watch_hit |=> !status.watch_hit) // RULE_14
    else $error("watch flag set while watching off");
  AST_RANGE: assert property (pos <= POS_MAX && pos >= POS_MIN) // RULE_04
    else $error("position count out of range");
  AST_REFUSE: assert property (mode == m_idle && !load_pend && move_req
    && !in_range && !estop_evt |=> move_refused && mode == m_idle) // RULE_23
    else $error("out of range move not refused");
  AST_HOME_LOAD: assert property (mode == m_home && home_found
    |=> pos == $past(cfg.ref_off)) // RULE_07
    else $error("offset not loaded on home");
  AST_FAST_RAMP: assert property (s_fast_start
    |=> cur_rate == $past(cfg.run_rate) && mode == m_fast) // RULE_10
    else $error("fast jog not started at run rate");
  AST_DIR: assert property (
    step_out |-> dir_out == ($past(move_neg) ^ $past(cfg.dir_level))) // RULE_12
    else $error("direction level not applied");
  AST_SAVE: assert property (save_yes && !load_pend
    |=> nv_wr && nv_wdata == {$past(cfg), $past(glob)}) // RULE_16
    else $error("save did not write full image");
  AST_DISP: assert property (
    $past(cfg.kind) == rotary_axis_type |-> disp_pos >= 0) // RULE_02
    else $error("rotary display negative");
endmodule
`default_nettype wire

// File: verilog/sac_pkg.sv
`default_nettype none
package sac_pkg;
  // ***********************
  // clock and timing
  // ***********************
  localparam int CLK_HZ = 20_000_000;
  localparam int RAMP_TIME_US = 100;  // one ramp increment per interval
  localparam int RAMP_CYC = CLK_HZ / 1_000_000 * RAMP_TIME_US;
  localparam logic [15:0] RAMP_INC = 16'h000a;
  // ***********************
  // position limits
  // ***********************
  localparam int STEP_MAX = 8_388_607;  // two to the 23rd minus one
  localparam logic signed [23:0] POS_MAX = 24'sh7fffff;
  localparam logic signed [23:0] POS_MIN = 24'sh800001;
  localparam int DEG_TURN = 360;
  // ***********************
  // host link
  // ***********************
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam int BAUD_0 = 2400;
  localparam int BAUD_1 = 4800;
  localparam int BAUD_2 = 9600;
  localparam int BAUD_3 = 19200;
  // ***********************
  // types
  // ***********************
  typedef enum logic [1:0] {
    rotary_axis_type, translation_axis_type, aperture_axis_type
  } sac_axis_kind_t;
  typedef enum logic [1:0] {par_none, par_even, par_odd, par_null} sac_par_t;
  typedef struct packed {
    sac_axis_kind_t kind;
    logic [15:0] steps_scale_mult;
    logic [15:0] steps_scale_div;
    logic signed [23:0] ref_off;
    logic [15:0] home_search_step_rate;
    logic [15:0] run_rate;
    logic [15:0] fast_rate;
    logic dir_level;
    logic lim_assign;
  } sac_cfg_t;
  typedef struct packed {
    logic io_watch;
    logic host_serial;
    logic [4:0] gpib_addr;
    logic [1:0] baud_sel;
    logic data8;
    logic stop2;
    sac_par_t parity;
    logic term_cr;
  } sac_glob_t;
  typedef struct packed {
    sac_cfg_t cfg;
    sac_glob_t glob;
  } sac_nv_t;
  typedef struct packed {
    logic host_serial;
    logic [4:0] gpib_addr;
    logic [13:0] baud_div;
    logic data8;
    logic stop2;
    sac_par_t parity;
    logic [7:0] term_char;
  } sac_link_t;
  typedef struct packed {
    logic lim_pos_hit;
    logic lim_neg_hit;
    logic watch_hit;
    logic stop_hit;
  } sac_stat_t;
  // ***********************
  // reset values
  // ***********************
  localparam sac_cfg_t CFG_DEF = '{kind: rotary_axis_type,
    steps_scale_mult: 16'h03e8, steps_scale_div: 16'h0001,
    ref_off: 24'sh000000, home_search_step_rate: 16'h05dc,
    run_rate: 16'h00fa, fast_rate: 16'h09c4,
    dir_level: 1'b0, lim_assign: 1'b0};
  localparam sac_glob_t GLOB_DEF = '{io_watch: 1'b0, host_serial: 1'b0,
    gpib_addr: 5'h01, baud_sel: 2'h2, data8: 1'b1, stop2: 1'b0,
    parity: par_none, term_cr: 1'b0};
endpackage
`default_nettype wire

// File: bench/sac_field_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***********************
// motor driver, storage and host stand-in
// ***********************
module sac_field_model (
  // clock
  input wire logic sys_clk,
  // storage port
  input wire logic nv_wr,
  input wire sac_pkg::sac_nv_t nv_wdata,
  output sac_pkg::sac_nv_t nv_rdata,
  // motor driver
  input wire logic step_out,
  input wire logic dir_out,
  // host byte stream
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  import sac_pkg::*;
  int steps = 0;
  // storage outlives resets; only a write changes it
  initial nv_rdata = '{cfg: CFG_DEF, glob: GLOB_DEF};
  always @(posedge sys_clk) begin
    if (nv_wr === 1'b1) begin
      nv_rdata <= nv_wdata;
    end
  end
  // raw pulse count, direction low taken as up
  always @(posedge sys_clk) begin
    if (step_out === 1'b1) begin
      steps <= dir_out ? steps - 1 : steps + 1;
    end
  end
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h55;
  end
  // released data is inverted so a stale byte never looks valid
  task automatic send_byte(input logic [7:0] b);
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_byte = b;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
  endtask
  // every command closes with carriage return then line feed
  task automatic send_cmd(input logic [7:0] c);
    send_byte(c);
    send_byte(CHAR_CR);
    send_byte(CHAR_LF);
  endtask
endmodule
`default_nettype wire

// File: bench/stepper_axis_config_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none
module stepper_axis_config_unit_bench;
  import sac_pkg::*;
  // ***********************
  // signals
  // ***********************
  logic sys_clk, reset, cfg_wr, save_yes, move_req, home_req, home_neg;
  logic home_found, jog_run, jog_fast, jog_neg, stop_req, lim_a, lim_b;
  logic stat_clr, rx_valid, nv_wr, move_refused, busy, step_out, dir_out;
  logic disp_deg, cmd_end, got_ref;
  logic [7:0] rx_byte;
  logic [15:0] watch_in;
  logic signed [15:0] move_target;
  logic signed [23:0] pos, p0;
  logic signed [26:0] disp_pos;
  sac_cfg_t cfg_in;
  sac_glob_t glob_in;
  sac_nv_t nv_rdata, nv_wdata;
  sac_stat_t status;
  sac_link_t link;
  int n_fail = 0;
  int n_tests = 0;
  int n_end = 0;
  int s0, d;
  int baud[4] = '{BAUD_0, BAUD_1, BAUD_2, BAUD_3};
  sac_axis uut (
    .sys_clk(sys_clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .glob_in(glob_in), .save_yes(save_yes), .nv_rdata(nv_rdata),
    .nv_wdata(nv_wdata), .nv_wr(nv_wr), .move_req(move_req),
    .move_target(move_target), .home_req(home_req), .home_neg(home_neg),
    .home_found(home_found), .jog_run(jog_run), .jog_fast(jog_fast),
    .jog_neg(jog_neg), .stop_req(stop_req), .move_refused(move_refused),
    .busy(busy), .lim_a(lim_a), .lim_b(lim_b), .watch_in(watch_in),
    .step_out(step_out), .dir_out(dir_out), .pos(pos), .disp_pos(disp_pos),
    .disp_deg(disp_deg), .stat_clr(stat_clr), .status(status),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_end(cmd_end), .link(link)
  );
  sac_field_model fld (
    .sys_clk(sys_clk), .nv_wr(nv_wr), .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata), .step_out(step_out), .dir_out(dir_out),
    .rx_valid(rx_valid), .rx_byte(rx_byte)
  );
  // ***********************
  // helpers
  // ***********************
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      $display("wrong value at %0t ns: %s", $time, msg);
      n_fail++;
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // three extra cycles cover the load cycle and the link update
  task automatic do_reset();
    reset = 1'b1;
    ticks(3);
    reset = 1'b0;
    ticks(3);
  endtask
  task automatic set_cfg();
    cfg_wr = 1'b1;
    ticks(1);
    cfg_wr = 1'b0;
    ticks(2);
  endtask
  task automatic move(input logic signed [15:0] t);
    move_target = t;
    move_req = 1'b1;
    ticks(1);
    // refusal stands for one cycle only, so catch it here
    got_ref = move_refused;
    move_req = 1'b0;
    ticks(1);
  endtask
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) ticks(1);
    chk(busy === 1'b0, "busy stuck");
  endtask
  // 700 cycles is two pulses at the top rate
  task automatic jog(input logic neg, output int dd);
    s0 = fld.steps;
    jog_neg = neg;
    jog_run = 1'b1;
    ticks(700);
    jog_run = 1'b0;
    wait_idle(10);
    dd = fld.steps - s0;
  endtask
  // ***********************
  // scenarios
  // ***********************
  task automatic t_defaults();
    chk(pos === CFG_DEF.ref_off, "reset position");
    chk(disp_deg === 1'b1, "rotary in degrees");
    chk(link.baud_div === 14'(CLK_HZ / BAUD_2), "baud divider");
    chk(link.term_char === CHAR_LF, "reply terminator");
    chk(link.gpib_addr === 5'h01, "bus address");
    chk({nv_wdata.cfg.home_search_step_rate, nv_wdata.cfg.run_rate,
      nv_wdata.cfg.fast_rate} === {16'h05dc, 16'h00fa, 16'h09c4},
      "default rates");
  endtask
  task automatic t_link();
    for (int b = 0; b < 4; b++) begin
      glob_in.baud_sel = 2'(b);
      glob_in.parity = sac_par_t'(b);
      glob_in.data8 = b[0];
      glob_in.stop2 = b[1];
      glob_in.host_serial = b[0];
      glob_in.gpib_addr = 5'(b + 3);
      glob_in.term_cr = b[1];
      set_cfg();
      chk(link.baud_div === 14'(CLK_HZ / baud[b]), "baud");
      chk(link.parity === glob_in.parity, "parity");
      chk({link.data8, link.stop2} === {b[0], b[1]}, "framing");
      chk(link.host_serial === b[0], "host port");
      chk(link.gpib_addr === 5'(b + 3), "address");
      chk(link.term_char === (b[1] ? CHAR_CR : CHAR_LF), "term");
    end
    glob_in = GLOB_DEF;
    set_cfg();
  endtask
  task automatic t_move();
    cfg_in.kind = translation_axis_type;
    cfg_in.steps_scale_mult = 16'h0003;
    cfg_in.steps_scale_div = 16'h0002;
    cfg_in.run_rate = 16'hffff; // model has no start-stop limit
    set_cfg();
    chk(disp_deg === 1'b0, "linear in mm");
    s0 = fld.steps;
    move(16'sd3);
    chk(busy === 1'b1, "move started");
    wait_idle(3000);
    chk(pos === 24'sd4, "4.5 steps cut to 4");
    chk(fld.steps - s0 === 4, "pulses sent");
    cfg_in.dir_level = 1'b1;
    set_cfg();
    move(-16'sd1);
    ticks(10);
    chk(dir_out === 1'b0, "inverted direction");
    wait_idle(3000);
    chk(pos === -24'sd1, "reverse move cut");
    chk(fld.steps - s0 === 9, "pulse count");
  endtask
  task automatic t_refuse();
    cfg_in = CFG_DEF;
    set_cfg();
    p0 = pos;
    move(16'sd9000);
    chk(got_ref === 1'b1, "target too far");
    chk(busy === 1'b0, "no motion");
    ticks(1);
    chk(move_refused === 1'b0, "one-cycle pulse");
    move(-16'sd8389);
    chk(got_ref === 1'b1, "negative bound");
    chk(pos === p0, "position kept");
  endtask
  task automatic t_watch();
    cfg_in.steps_scale_mult = 16'h0001;
    cfg_in.run_rate = 16'hffff;
    set_cfg();
    move(16'sd100);
    watch_in[3] = 1'b1;
    ticks(3);
    chk(busy === 1'b1, "port not watched");
    watch_in = '0;
    glob_in.io_watch = 1'b1;
    set_cfg();
    watch_in[9] = 1'b1;
    ticks(1);
    s0 = fld.steps;
    p0 = pos;
    ticks(2);
    chk(busy === 1'b0, "watched edge stops");
    chk(status.watch_hit === 1'b1, "watch status");
    ticks(400);
    chk(fld.steps === s0 && pos === p0, "pulse after stop");
    stat_clr = 1'b1;
    ticks(1);
    stat_clr = 1'b0;
    chk(status.watch_hit === 1'b0, "status clear");
    // stop request in mid move
    move(16'sd100);
    stop_req = 1'b1;
    ticks(1);
    stop_req = 1'b0;
    ticks(1);
    chk(busy === 1'b0, "stop request ignored");
    chk(status.stop_hit === 1'b1, "stop status");
  endtask
  // two ramp steps each way, so slowing down takes over one interval
  task automatic t_fast();
    cfg_in.run_rate = 16'hffe0;
    cfg_in.fast_rate = 16'hfff4;
    set_cfg();
    jog_neg = 1'b0;
    jog_fast = 1'b1;
    ticks(2 * RAMP_CYC + 100);
    chk(uut.cur_rate === 16'hfff4, "fast rate not reached");
    jog_fast = 1'b0;
    ticks(5);
    chk(busy === 1'b1, "no ramp down");
    wait_idle(2 * RAMP_CYC + 10);
    chk(uut.cur_rate === 16'hffe0, "not back at run rate");
  endtask
  task automatic t_limit();
    glob_in.io_watch = 1'b0;
    set_cfg();
    lim_a = 1'b1;
    jog(1'b0, d);
    chk(d === 0, "stepped into limit");
    chk(status.lim_pos_hit === 1'b1, "limit status");
    jog(1'b1, d);
    chk(d < 0, "cannot run off limit");
    cfg_in.lim_assign = 1'b1;
    set_cfg();
    jog(1'b0, d);
    chk(d > 0, "assignment ignored");
    lim_a = 1'b0;
  endtask
  task automatic t_home();
    cfg_in.home_search_step_rate = 16'hffff;
    cfg_in.run_rate = CFG_DEF.run_rate;
    cfg_in.ref_off = 24'sd77;
    set_cfg();
    s0 = fld.steps;
    home_req = 1'b1;
    ticks(1);
    home_req = 1'b0;
    ticks(700);
    chk(fld.steps - s0 === 2, "home search rate");
    home_found = 1'b1;
    ticks(1);
    home_found = 1'b0;
    wait_idle(5);
    chk(pos === 24'sd77, "offset after home");
  endtask
  task automatic t_host();
    n_end = 0;
    fld.send_cmd(8'h3f);
    ticks(3);
    chk(n_end === 1, "command end");
    fld.send_byte(CHAR_LF);
    ticks(3);
    chk(n_end === 1, "lone line feed");
  endtask
  task automatic t_save();
    cfg_in = CFG_DEF;
    cfg_in.ref_off = 24'sd370000;
    set_cfg();
    save_yes = 1'b1;
    ticks(1);
    save_yes = 1'b0;
    ticks(2);
    chk(nv_rdata.cfg === cfg_in, "image stored");
    cfg_in.ref_off = 24'sd5;
    set_cfg();
    do_reset();
    chk(pos === 24'sd370000, "edit lost on reset");
    chk(disp_pos === 27'sd10000, "display one turn");
    chk(disp_deg === 1'b1, "degrees");
  endtask
  // ***********************
  // run control
  // ***********************
  always @(posedge sys_clk) begin
    if (cmd_end === 1'b1) n_end++;
  end
  task automatic results();
    $display("tests %0d, failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // normal run is about 13k cycles; 30k leaves room for slow rates
  initial begin
    #1_500_000;
    n_fail++;
    results();
  end
  initial begin
    reset = 1'b1;
    {cfg_wr, save_yes, move_req, home_req, home_neg, home_found} = '0;
    {jog_run, jog_fast, jog_neg, stop_req, lim_a, lim_b, stat_clr} = '0;
    cfg_in = CFG_DEF;
    glob_in = GLOB_DEF;
    move_target = '0;
    watch_in = '0;
    do_reset();
    t_defaults();
    t_link();
    t_move();
    t_refuse();
    t_watch();
    t_limit();
    t_fast();
    t_home();
    t_host();
    t_save();
    results();
  end
endmodule
`default_nettype wire
